// *** rtl/dtc_pkg.sv ***
`default_nettype none
package dtc_pkg;
  // special-function addresses
  localparam logic [7:0] DTC_ADDR_RUN_FLAG = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE_CFG = 8'h89;
  localparam logic [7:0] DTC_ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] DTC_ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] DTC_ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] DTC_ADDR_T1_HIGH = 8'h8D;
  // reset values
  localparam logic [7:0] DTC_MODE_CFG_RST = 8'h00;
  localparam logic [7:0] DTC_RUN_FLAG_RST = 8'h00;
  localparam logic [7:0] DTC_COUNT_RST = 8'h00;
  localparam logic [7:0] DTC_RDATA_IDLE = 8'h00;
  // mode register field positions
  localparam int DTC_T1_GATE_BIT = 7;
  localparam int DTC_T1_SRC_BIT = 6;
  localparam int DTC_T1_MODE_HI = 5;
  localparam int DTC_T1_MODE_LO = 4;
  localparam int DTC_T0_GATE_BIT = 3;
  localparam int DTC_T0_SRC_BIT = 2;
  localparam int DTC_T0_MODE_HI = 1;
  localparam int DTC_T0_MODE_LO = 0;
  // run/flag register field positions
  localparam int DTC_T1_FLAG_BIT = 7;
  localparam int DTC_T1_RUN_BIT = 6;
  localparam int DTC_T0_FLAG_BIT = 5;
  localparam int DTC_T0_RUN_BIT = 4;
  localparam int DTC_EXT_INT_MSB = 3;
  // operating modes
  localparam logic [1:0] DTC_MODE_PRESCALE = 2'h0;
  localparam logic [1:0] DTC_MODE_CASCADE = 2'h1;
  localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
  localparam logic [1:0] DTC_MODE_SPLIT = 2'h3;
  // prescaler width in mode 00
  localparam int DTC_PRESCALE_BITS = 5;
endpackage : dtc_pkg
`default_nettype wire

// *** rtl/dtc_count_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_count_unit
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic [1:0] mode,
  input wire logic tick_low,
  input wire logic tick_high,
  // software load
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  // count and overflow
  output logic [7:0] count_low_byte,
  output logic [7:0] count_high_byte,
  output logic ovf_main,
  output logic ovf_high
);
  localparam int PW = DTC_PRESCALE_BITS;

  logic [7:0] low_nxt;
  logic [7:0] high_nxt;
  logic [PW+7:0] pair13;
  logic [16:0] pair16;
  logic [8:0] low_inc;
  logic [8:0] high_inc;

  always_comb
  begin
    low_nxt = count_low_byte;
    high_nxt = count_high_byte;
    ovf_main = 1'b0;
    ovf_high = 1'b0;
    pair13 = {count_high_byte, count_low_byte[PW-1:0]} + 1'b1;
    pair16 = {1'b0, count_high_byte, count_low_byte} + 17'h00001;
    low_inc = {1'b0, count_low_byte} + 9'h001;
    high_inc = {1'b0, count_high_byte} + 9'h001;
    case (mode)
      DTC_MODE_PRESCALE:
        if (tick_low)
        begin
          // upper three low-byte bits are left alone in this mode
          low_nxt = {count_low_byte[7:PW], pair13[PW-1:0]};
          high_nxt = pair13[PW+7:PW];
          ovf_main = &{count_high_byte, count_low_byte[PW-1:0]};
        end
      DTC_MODE_CASCADE:
        if (tick_low)
        begin
          {high_nxt, low_nxt} = pair16[15:0];
          ovf_main = pair16[16];
        end
      DTC_MODE_RELOAD:
        if (tick_low)
        begin
          low_nxt = low_inc[8] ? count_high_byte : low_inc[7:0];
          ovf_main = low_inc[8];
        end
      DTC_MODE_SPLIT:
      begin
        if (tick_low)
        begin
          low_nxt = low_inc[7:0];
          ovf_main = low_inc[8];
        end
        if (tick_high)
        begin
          high_nxt = high_inc[7:0];
          ovf_high = high_inc[8];
        end
      end
      default:
      begin
        low_nxt = count_low_byte;
      end
    endcase
  end

  // a software load takes priority over a count in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_low_byte <= DTC_COUNT_RST;
    else if (wr_low)
      count_low_byte <= wdata;
    else
      count_low_byte <= low_nxt;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_high_byte <= DTC_COUNT_RST;
    else if (wr_high)
      count_high_byte <= wdata;
    else
      count_high_byte <= high_nxt;
  end
endmodule : dtc_count_unit
`default_nettype wire

// *** rtl/dtc_timer_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - timer function adds one to the low byte every core clock
// - counter function counts a high sample followed by a low sample
// - each timer is two 8-bit bytes, timer or event counter
// - mode register at 89H, reset 00H, four bits per timer
// - bit 7 set: timer 1 counts only while gating pin one high
// - bit 3 set: timer 0 counts only while gating pin zero high
// - bit 6 picks timer 1 source: external edges or core clock
// - bit 2 picks timer 0 source: external edges or core clock
// - timer 1 mode from bits 5:4, timer 0 mode from bits 1:0
// - mode 00: 8-bit high byte behind a 5-bit low prescaler
// - mode 01: low and high bytes cascade into 16 bits
// - mode 10: low byte counts, reloads from high byte on overflow
// - timer 1 in mode 11 holds its count
// - timer 0 mode 11: low byte own controls, high byte timer 1 run
// - run bits 6 and 4 at 88H start and stop the timers
// - overflow sets flag bit 7 or 5; vectoring clears it
module dtc_timer_top
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // interrupt vectoring acknowledges
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  // pins
  input wire logic count_input_zero,
  input wire logic count_input_one,
  input wire logic gating_pin_zero,
  input wire logic gating_pin_one,
  // overflow flags to the interrupt controller
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag
);
  logic [7:0] timer_mode_config_r;
  logic timer0_run_bit_r;
  logic timer1_run_bit_r;
  logic [DTC_EXT_INT_MSB:0] ext_int_bits_r;
  logic cnt0_prev_r;
  logic cnt1_prev_r;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic run0;
  logic run1;
  logic tick0;
  logic tick1;
  logic tick0_high;
  logic edge0;
  logic edge1;
  logic ovf0;
  logic ovf1;
  logic ovf0_high;
  logic set0;
  logic set1;
  logic [7:0] timer0_low_byte;
  logic [7:0] timer0_high_byte;
  logic [7:0] timer1_low_byte;
  logic [7:0] timer1_high_byte;
  logic wr_cfg;
  logic wr_ctl;
  logic wr_t0_low;
  logic wr_t0_high;
  logic wr_t1_low;
  logic wr_t1_high;

  assign wr_cfg = sfr_wr && (sfr_addr == DTC_ADDR_MODE_CFG);
  assign wr_ctl = sfr_wr && (sfr_addr == DTC_ADDR_RUN_FLAG);
  // byte loads go straight into the count; no latch pairs the two halves
  assign wr_t0_low = sfr_wr && (sfr_addr == DTC_ADDR_T0_LOW);
  assign wr_t0_high = sfr_wr && (sfr_addr == DTC_ADDR_T0_HIGH);
  assign wr_t1_low = sfr_wr && (sfr_addr == DTC_ADDR_T1_LOW);
  assign wr_t1_high = sfr_wr && (sfr_addr == DTC_ADDR_T1_HIGH);
  assign mode1 = {timer_mode_config_r[DTC_T1_MODE_HI],
                  timer_mode_config_r[DTC_T1_MODE_LO]};
  assign mode0 = {timer_mode_config_r[DTC_T0_MODE_HI],
                  timer_mode_config_r[DTC_T0_MODE_LO]};

  // pins are synchronous, so one stored sample is enough for edge detection
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt0_prev_r <= 1'b0;
      cnt1_prev_r <= 1'b0;
    end
    else
    begin
      cnt0_prev_r <= count_input_zero;
      cnt1_prev_r <= count_input_one;
    end
  end

  // a pulse narrower than one clock can be missed entirely
  assign edge0 = cnt0_prev_r && !count_input_zero;
  assign edge1 = cnt1_prev_r && !count_input_one;

  assign run0 = timer0_run_bit_r &&
                (!timer_mode_config_r[DTC_T0_GATE_BIT] || gating_pin_zero);
  assign run1 = timer1_run_bit_r &&
                (!timer_mode_config_r[DTC_T1_GATE_BIT] || gating_pin_one);
  assign tick0 = run0 && (timer_mode_config_r[DTC_T0_SRC_BIT] ? edge0 : 1'b1);
  assign tick1 = run1 && (mode1 != DTC_MODE_SPLIT) &&
                 (timer_mode_config_r[DTC_T1_SRC_BIT] ? edge1 : 1'b1);
  // split high byte counts core clocks only, on the timer 1 run bit alone
  assign tick0_high = (mode0 == DTC_MODE_SPLIT) && timer1_run_bit_r;

  dtc_count_unit u_timer0 (
    .core_clk(core_clk),
    .rst(rst),
    .mode(mode0),
    .tick_low(tick0),
    .tick_high(tick0_high),
    .wr_low(wr_t0_low),
    .wr_high(wr_t0_high),
    .wdata(sfr_wdata),
    .count_low_byte(timer0_low_byte),
    .count_high_byte(timer0_high_byte),
    .ovf_main(ovf0),
    .ovf_high(ovf0_high)
  );

  dtc_count_unit u_timer1 (
    .core_clk(core_clk),
    .rst(rst),
    .mode(mode1),
    .tick_low(tick1),
    .tick_high(1'b0),
    .wr_low(wr_t1_low),
    .wr_high(wr_t1_high),
    .wdata(sfr_wdata),
    .count_low_byte(timer1_low_byte),
    .count_high_byte(timer1_high_byte),
    .ovf_main(ovf1),
    .ovf_high()
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      timer_mode_config_r <= DTC_MODE_CFG_RST;
    else if (wr_cfg)
      timer_mode_config_r <= sfr_wdata;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timer0_run_bit_r <= DTC_RUN_FLAG_RST[DTC_T0_RUN_BIT];
      timer1_run_bit_r <= DTC_RUN_FLAG_RST[DTC_T1_RUN_BIT];
      ext_int_bits_r <= DTC_RUN_FLAG_RST[DTC_EXT_INT_MSB:0];
    end
    else if (wr_ctl)
    begin
      timer0_run_bit_r <= sfr_wdata[DTC_T0_RUN_BIT];
      timer1_run_bit_r <= sfr_wdata[DTC_T1_RUN_BIT];
      ext_int_bits_r <= sfr_wdata[DTC_EXT_INT_MSB:0];
    end
  end

  assign set0 = ovf0;
  assign set1 = ovf1 || ((mode0 == DTC_MODE_SPLIT) && ovf0_high);

  // hardware set wins over a vector clear or software write in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      timer0_overflow_flag <= DTC_RUN_FLAG_RST[DTC_T0_FLAG_BIT];
    else if (set0)
      timer0_overflow_flag <= 1'b1;
    else if (timer0_vector_ack)
      timer0_overflow_flag <= 1'b0;
    else if (wr_ctl)
      timer0_overflow_flag <= sfr_wdata[DTC_T0_FLAG_BIT];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      timer1_overflow_flag <= DTC_RUN_FLAG_RST[DTC_T1_FLAG_BIT];
    else if (set1)
      timer1_overflow_flag <= 1'b1;
    else if (timer1_vector_ack)
      timer1_overflow_flag <= 1'b0;
    else if (wr_ctl)
      timer1_overflow_flag <= sfr_wdata[DTC_T1_FLAG_BIT];
  end

  // read data registered one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sfr_rdata <= DTC_RDATA_IDLE;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        DTC_ADDR_RUN_FLAG:
          sfr_rdata <= {timer1_overflow_flag, timer1_run_bit_r,
                        timer0_overflow_flag, timer0_run_bit_r, ext_int_bits_r};
        DTC_ADDR_MODE_CFG: sfr_rdata <= timer_mode_config_r;
        DTC_ADDR_T0_LOW: sfr_rdata <= timer0_low_byte;
        DTC_ADDR_T1_LOW: sfr_rdata <= timer1_low_byte;
        DTC_ADDR_T0_HIGH: sfr_rdata <= timer0_high_byte;
        DTC_ADDR_T1_HIGH: sfr_rdata <= timer1_high_byte;
        default: sfr_rdata <= DTC_RDATA_IDLE;
      endcase
    end
  end
endmodule : dtc_timer_top
`default_nettype wire

// *** sim/dtc_timer_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // acks and flags
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag
);
  logic [7:0] mode_r;
  logic [1:0] run_r;
  logic wr_run;
  logic t1_live;
  assign wr_run = sfr_wr && sfr_addr == 8'h88;
  // split timer 0 lends timer 1's flag to its high byte
  assign t1_live = run_r[1] && (mode_r[5:4] != 2'h3 || mode_r[1:0] == 2'h3);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= 8'h00;
      run_r <= 2'h0;
    end
    else
    begin
      if (sfr_wr && sfr_addr == 8'h89)
        mode_r <= sfr_wdata;
      if (wr_run)
        run_r <= {sfr_wdata[6], sfr_wdata[4]};
    end
  end
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8D)
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  mode_read_a: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h89
    |=> sfr_rdata == mode_r) else $error("mode read wrong");
  run_read_a: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h88
    |=> {sfr_rdata[6], sfr_rdata[4]} == run_r) else $error("run bits read wrong");
  flag_clear_a: assert property ($fell(timer0_overflow_flag)
    |-> $past(timer0_vector_ack) || $past(wr_run)) else $error("flag 0 fell unasked");
  flag_keep_a: assert property (timer1_overflow_flag && !timer1_vector_ack && !wr_run
    |=> timer1_overflow_flag) else $error("flag 1 not sticky");
  flag0_run_a: assert property ($rose(timer0_overflow_flag)
    |-> $past(run_r[0]) || $past(wr_run)) else $error("flag 0 set while stopped");
  flag1_run_a: assert property ($rose(timer1_overflow_flag)
    |-> $past(t1_live) || $past(wr_run)) else $error("flag 1 set while stopped");
  cover property ($rose(timer0_overflow_flag));
  cover property ($rose(timer1_overflow_flag));
  cover property (timer0_vector_ack && timer0_overflow_flag);
  cover property (timer1_vector_ack && timer1_overflow_flag);
endmodule : dtc_timer_monitor
bind dtc_timer_top dtc_timer_monitor mon (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .timer0_vector_ack, .timer1_vector_ack, .timer0_overflow_flag,
  .timer1_overflow_flag);
`default_nettype wire

// *** sim/dtc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  // pins toward the device
  input wire logic core_clk,
  output logic count_input_zero,
  output logic count_input_one,
  output logic gating_pin_zero,
  output logic gating_pin_one
);
  initial
  begin
    count_input_zero = 1'h0;
    count_input_one = 1'h0;
    gating_pin_zero = 1'h0;
    gating_pin_one = 1'h0;
  end
  task automatic gates(input logic g);
    @(posedge core_clk);
    gating_pin_zero <= g;
    gating_pin_one <= g;
  endtask : gates
  // two clocks per level, so a sampler never misses one
  task automatic pulses(input int n);
    repeat (2 * n)
    begin
      repeat (2) @(posedge core_clk);
      count_input_zero <= !count_input_zero;
      count_input_one <= !count_input_one;
    end
  endtask : pulses
endmodule : dtc_pin_model
`default_nettype wire

// *** sim/dtc_timer_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_top_bench;
  logic core_clk;
  logic rst;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic sfr_wr, sfr_rd, timer0_vector_ack, timer1_vector_ack;
  logic count_input_zero, count_input_one, gating_pin_zero, gating_pin_one;
  logic timer0_overflow_flag, timer1_overflow_flag;
  int n_fail;
  int tests_run;
  dtc_timer_top dut (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .timer0_vector_ack, .timer1_vector_ack, .count_input_zero, .count_input_one,
    .gating_pin_zero, .gating_pin_one, .timer0_overflow_flag, .timer1_overflow_flag);
  dtc_pin_model pins (.core_clk, .count_input_zero, .count_input_one, .gating_pin_zero,
    .gating_pin_one);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'h1;
    @(posedge core_clk);
    sfr_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'h1;
    @(posedge core_clk);
    sfr_rd <= 1'h0;
    #1;
    check(what, sfr_rdata, exp);
  endtask : rd
  // one-cycle vector acknowledge to timer 0 (one = 0) or timer 1 (one = 1)
  task automatic pulse_ack(input logic one);
    @(posedge core_clk);
    timer0_vector_ack <= !one;
    timer1_vector_ack <= one;
    @(posedge core_clk);
    timer0_vector_ack <= 1'h0;
    timer1_vector_ack <= 1'h0;
    #1;
  endtask : pulse_ack
  // start, then n+2 counting edges before the stop lands
  task automatic run(input logic [7:0] v, input int n);
    wr(8'h88, v);
    repeat (n) @(posedge core_clk);
    wr(8'h88, 8'h00);
  endtask : run
  task automatic kick(input logic [7:0] v);
    wr(8'h88, v);
    repeat (2) @(posedge core_clk);
    #1;
  endtask : kick
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    core_clk = 1'h0;
    forever #20 core_clk = !core_clk;
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    rst = 1'h1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    {sfr_wr, sfr_rd, timer0_vector_ack, timer1_vector_ack} = 4'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'h0;
    rd(8'h89, 8'h00, "mode");
    rd(8'h88, 8'h00, "run");
    rd(8'h8F, 8'h00, "unmapped");
    wr(8'h89, 8'hA5);
    rd(8'h89, 8'hA5, "mode");
    $display("test registers done");
    wr(8'h89, 8'h01);
    wr(8'h8A, 8'hF0);
    wr(8'h8C, 8'h12);
    run(8'h10, 20);
    rd(8'h8A, 8'h06, "t0 low");
    rd(8'h8C, 8'h13, "t0 high");
    $display("test cascade done");
    wr(8'h89, 8'h99);
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'h00);
    run(8'h50, 20);
    rd(8'h8A, 8'h00, "gated low");
    rd(8'h8B, 8'h00, "gated low t1");
    pins.gates(1'h1);
    run(8'h50, 20);
    rd(8'h8A, 8'h16, "gated high");
    rd(8'h8B, 8'h16, "gated high t1");
    $display("test gating done");
    wr(8'h89, 8'h55);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h00);
    wr(8'h88, 8'h50);
    pins.pulses(5);
    wr(8'h88, 8'h00);
    rd(8'h8A, 8'h05, "t0 events");
    rd(8'h8B, 8'h05, "t1 events");
    $display("test counter done");
    wr(8'h89, 8'h00);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFF);
    kick(8'h10);
    check("flag0", {7'h00, timer0_overflow_flag}, 8'h01);
    pulse_ack(1'h0);
    check("flag0", {7'h00, timer0_overflow_flag}, 8'h00);
    wr(8'h88, 8'h00);
    rd(8'h8A, 8'hE4, "t0 low");
    rd(8'h8C, 8'h00, "t0 high");
    $display("test prescale done");
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hF0);
    wr(8'h8B, 8'hFE);
    kick(8'h40);
    check("flag1", {7'h00, timer1_overflow_flag}, 8'h01);
    pulse_ack(1'h1);
    check("flag1 ack", {7'h00, timer1_overflow_flag}, 8'h00);
    wr(8'h88, 8'h00);
    rd(8'h8B, 8'hF4, "t1 low");
    rd(8'h8D, 8'hF0, "t1 high");
    $display("test reload done");
    wr(8'h89, 8'h33);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h00);
    kick(8'h40);
    check("flag1", {7'h00, timer1_overflow_flag}, 8'h01);
    wr(8'h88, 8'h00);
    rd(8'h8C, 8'h02, "t0 high");
    rd(8'h8A, 8'h00, "t0 low");
    rd(8'h8B, 8'h00, "t1 low");
    $display("test split done");
    give_verdict();
  end
endmodule : dtc_timer_top_bench
`default_nettype wire
